// ==== rtl/fpeg_consts.vh ====
// Constants for the flash program/erase guard: register offsets, fields, resets, timing.
// Assumes a 25 MHz system clock and a 32-bit Avalon-MM register port.
`ifndef FPEG_CONSTS_VH
`define FPEG_CONSTS_VH

// Register byte offsets
`define FPEG_OFS_FLASH_CTRL   4'h0
`define FPEG_OFS_BLOCK_A      4'h4
`define FPEG_OFS_BLOCK_B      4'h8
`define FPEG_OFS_WAIT_STATE   4'hc
`define FPEG_OFS_COND_CODE    4'h0
`define FPEG_OFS_STATUS_HI    4'h4

// Flash control register fields
`define FPEG_FC_PROG          0
`define FPEG_FC_ERASE         1
`define FPEG_FC_VFY_WRITE     2
`define FPEG_FC_VFY_CLEAR     3

// Wait-state control register fields
`define FPEG_WS_OVL_HIGH      7
`define FPEG_WS_OVL_LOW       6
`define FPEG_WS_RESET         8'h08

// Condition code interrupt mask bit
`define FPEG_CC_IMASK         7
`define FPEG_CC_RESET         8'h80

// Prewrite-verify settle time
`define FPEG_PWV_NS           4000
`define FPEG_CLK_NS           40
`define FPEG_PWV_CYC          ((`FPEG_PWV_NS + `FPEG_CLK_NS - 1) / `FPEG_CLK_NS)

// Overlap window for vectors
`define FPEG_VEC_RAM_BASE     16'hf800
`define FPEG_VEC_LIMIT        16'h007f

`endif

// ==== rtl/fpeg_sync2.v ====
// Two flip-flop synchroniser for one level from outside the clock domain.
// Assumes nothing but the system clock and asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module fpeg_sync2 (
   input  wire clk_i,
   input  wire rst_i,
   input  wire d_i,
   output reg  q_o
);
   reg meta;

   // First stage feeds only the second
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta <= 1'b0;
         q_o  <= 1'b0;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule // fpeg_sync2
`default_nettype wire

// ==== rtl/fpeg_settle.v ====
// Settle counter: raises done after a whole number of cycles with start held.
// Assumes start_i is a level on the same clock.
`timescale 1ns/1ns
`default_nettype none
module fpeg_settle #(
   parameter CYCLES = 100,
   parameter W      = 8
) (
   input  wire clk_i,
   input  wire rst_i,
   input  wire start_i,
   output reg  done_o
);
   localparam [W-1:0] LAST = CYCLES - 1;  // Final count before done
   reg [W-1:0] count;

   // Restart whenever start drops
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         count  <= {W{1'b0}};
         done_o <= 1'b0;
      end else if (!start_i) begin
         count  <= {W{1'b0}};
         done_o <= 1'b0;
      end else if (count == LAST) begin
         done_o <= 1'b1;
      end else begin
         count <= count + 1'b1;
      end
   end
endmodule // fpeg_settle
`default_nettype wire

// ==== rtl/fpeg_guard.v ====
// Flash program/erase guard: control, block select and wait-state registers,
// software and hardware protection, interrupt abort and vector overlap.
// Assumes an Avalon-MM master on clk_i; pins program_voltage_pin_i,
// hw_standby_i, sw_standby_i, nmi_i and irq_i are asynchronous.
//
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "fpeg_consts.vh"
module fpeg_guard #(
   parameter NBLK_A = 8,
   parameter NBLK_B = 8
) (
   input  wire        clk_i,
   input  wire        rst_i,
   // Avalon-MM slave
   input  wire [3:0]  avs_address_i,
   input  wire        avs_read_i,
   input  wire        avs_write_i,
   input  wire [31:0] avs_writedata_i,
   input  wire [3:0]  avs_byteenable_i,
   input  wire        avs_chipselect_hi_i,
   output reg  [31:0] avs_readdata_o,
   output reg         avs_waitrequest_o,
   // Pins and system events
   input  wire        program_voltage_pin_i,
   input  wire        hw_standby_i,
   input  wire        sw_standby_i,
   input  wire        boot_mode_i,
   input  wire        nmi_i,
   input  wire        irq_i,
   input  wire [15:0] cpu_addr_i,
   // Flash array control
   output reg         flash_program_o,
   output reg         flash_erase_o,
   output reg         flash_verify_write_o,
   output reg         flash_verify_clear_o,
   output reg         flash_prewrite_verify_o,
   output reg         flash_read_valid_o,
   output reg  [NBLK_A-1:0] block_enable_a_o,
   output reg  [NBLK_B-1:0] block_enable_b_o,
   output reg         vector_from_ram_o,
   output reg  [15:0] mapped_addr_o,
   output reg         irq_taken_o
);
   // Software-visible registers, bus handshake flag and standby edge history
   reg [7:0]        flash_control_reg;
   reg [NBLK_A-1:0] erase_block_select_a;
   reg [NBLK_B-1:0] erase_block_select_b;
   reg [7:0]        wait_state_ctrl_reg;
   reg [7:0]        condition_code_reg;
   reg              abort_lock;
   reg              access_done;
   reg              hw_standby_d;
   reg              sw_standby_d;

   // Synchronised pins
   wire vpp_ok;
   wire hw_stby;
   wire sw_stby;
   wire nmi_s;
   wire irq_s;
   wire boot_s;

   fpeg_sync2 u_sync_vpp (.clk_i(clk_i), .rst_i(rst_i),
      .d_i(program_voltage_pin_i), .q_o(vpp_ok));
   fpeg_sync2 u_sync_hws (.clk_i(clk_i), .rst_i(rst_i), .d_i(hw_standby_i), .q_o(hw_stby));
   fpeg_sync2 u_sync_sws (.clk_i(clk_i), .rst_i(rst_i), .d_i(sw_standby_i), .q_o(sw_stby));
   fpeg_sync2 u_sync_nmi (.clk_i(clk_i), .rst_i(rst_i), .d_i(nmi_i), .q_o(nmi_s));
   fpeg_sync2 u_sync_irq (.clk_i(clk_i), .rst_i(rst_i), .d_i(irq_i), .q_o(irq_s));
   fpeg_sync2 u_sync_boot (.clk_i(clk_i), .rst_i(rst_i), .d_i(boot_mode_i), .q_o(boot_s));

   // Decoded control bits
   wire ovl_hi   = wait_state_ctrl_reg[`FPEG_WS_OVL_HIGH];
   wire ovl_lo   = wait_state_ctrl_reg[`FPEG_WS_OVL_LOW];
   wire ovl_both = ovl_hi & ovl_lo;
   wire ovl_one  = ovl_hi ^ ovl_lo;
   wire fc_prog  = flash_control_reg[`FPEG_FC_PROG];
   wire fc_erase = flash_control_reg[`FPEG_FC_ERASE];
   wire fc_vw    = flash_control_reg[`FPEG_FC_VFY_WRITE];
   wire fc_vc    = flash_control_reg[`FPEG_FC_VFY_CLEAR];
   wire busy     = fc_prog | fc_erase;

   // Interrupt source with mask flag; NMI is never masked
   wire imask   = condition_code_reg[`FPEG_CC_IMASK];
   wire boot_ok = ~boot_s;                            // Boot program allows NMI only
   wire irq_in  = nmi_s | (irq_s & ~imask & boot_ok);

   // Register clearing conditions
   wire stby_entry = (hw_stby & ~hw_standby_d) | (sw_stby & ~sw_standby_d);
   wire fc_clear   = ~vpp_ok | hw_stby | stby_entry;

   // Software protection: nothing selected, emulation active or abort lock set
   wire no_blocks  = (erase_block_select_a == {NBLK_A{1'b0}}) &&
                     (erase_block_select_b == {NBLK_B{1'b0}});
   wire sw_protect = ovl_one | no_blocks | abort_lock;

   // Bus decode
   wire       req   = avs_read_i | avs_write_i;
   wire       wr    = avs_write_i & access_done;  // Lands at the edge waitrequest is seen low
   wire [7:0] wbyte = avs_byteenable_i[0] ? avs_writedata_i[7:0] : 8'h00;
   wire       be0   = avs_byteenable_i[0];
   wire       be1   = avs_byteenable_i[1];

   // Edge history of standby levels
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         hw_standby_d <= 1'b0;
         sw_standby_d <= 1'b0;
      end else begin
         hw_standby_d <= hw_stby;
         sw_standby_d <= sw_stby;
      end
   end

   // Flash control and block select registers
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         flash_control_reg    <= 8'h00;
         erase_block_select_a <= {NBLK_A{1'b0}};
         erase_block_select_b <= {NBLK_B{1'b0}};
      end else if (fc_clear) begin
         flash_control_reg    <= 8'h00;
         erase_block_select_a <= {NBLK_A{1'b0}};
         erase_block_select_b <= {NBLK_B{1'b0}};
      end else if (wr && be0 && !avs_chipselect_hi_i) begin
         // Abort keeps contents; only software writes, reset and the clear conditions change them
         case (avs_address_i)
            `FPEG_OFS_FLASH_CTRL: flash_control_reg <= {4'h0, wbyte[3:0]};
            `FPEG_OFS_BLOCK_A:    erase_block_select_a <= wbyte[NBLK_A-1:0];
            `FPEG_OFS_BLOCK_B:    erase_block_select_b <= wbyte[NBLK_B-1:0];
            default: ;
         endcase
      end
   end

   // Wait-state register survives software standby
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_state_ctrl_reg <= `FPEG_WS_RESET;
      end else if (hw_stby) begin
         wait_state_ctrl_reg <= `FPEG_WS_RESET;
      end else if (wr && be0 && !avs_chipselect_hi_i &&
                   avs_address_i == `FPEG_OFS_WAIT_STATE) begin
         wait_state_ctrl_reg <= wbyte;
      end
   end

   // Condition code mirror, written by the CPU core
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         condition_code_reg <= `FPEG_CC_RESET;
      end else if (wr && be0 && avs_chipselect_hi_i &&
                   avs_address_i == `FPEG_OFS_COND_CODE) begin
         condition_code_reg <= wbyte;
      end
   end

   // Interrupt abort lock, cleared only by reset
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         abort_lock <= 1'b0;
      end else if (irq_in && busy && vpp_ok) begin
         abort_lock <= 1'b1;
      end
   end

   // Prewrite-verify settle timer
   wire pwv_mode = ~fc_clear & ~fc_prog & ~fc_erase & ~fc_vw & ~fc_vc;
   wire pwv_done;

   fpeg_settle #(.CYCLES(`FPEG_PWV_CYC), .W(8)) u_pwv (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (pwv_mode),
      .done_o  (pwv_done)
   );

   // Flash array drive; protection gates program and erase at once
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         flash_program_o         <= 1'b0;
         flash_erase_o           <= 1'b0;
         flash_verify_write_o    <= 1'b0;
         flash_verify_clear_o    <= 1'b0;
         flash_prewrite_verify_o <= 1'b0;
         flash_read_valid_o      <= 1'b1;
         block_enable_a_o        <= {NBLK_A{1'b0}};
         block_enable_b_o        <= {NBLK_B{1'b0}};
      end else begin
         // Standby or lost voltage stops the array in the cycle of the clear
         flash_program_o  <= fc_prog & ~fc_clear & ~sw_protect & ~irq_in;
         flash_erase_o    <= fc_erase & ~fc_clear & ~sw_protect & ~irq_in;
         flash_verify_write_o    <= fc_vw & ~fc_clear;
         flash_verify_clear_o    <= fc_vc & ~fc_clear;
         flash_prewrite_verify_o <= pwv_mode;
         flash_read_valid_o      <= ~busy & (~pwv_mode | pwv_done);
         // Emulation protect disables every block, no selective choice
         block_enable_a_o <= ovl_one ? {NBLK_A{1'b0}} : erase_block_select_a;
         block_enable_b_o <= ovl_one ? {NBLK_B{1'b0}} : erase_block_select_b;
      end
   end

   // Vector overlap: RAM window over low flash when armed
   wire in_vec = (cpu_addr_i <= `FPEG_VEC_LIMIT);
   wire ovl_on = ovl_both & vpp_ok & (irq_in | boot_s);

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         vector_from_ram_o <= 1'b0;
         mapped_addr_o     <= 16'h0000;
         irq_taken_o       <= 1'b0;
      end else begin
         vector_from_ram_o <= ovl_on & in_vec;
         mapped_addr_o     <= (ovl_on & in_vec) ? (cpu_addr_i | `FPEG_VEC_RAM_BASE)
                                                : cpu_addr_i;
         irq_taken_o       <= irq_in;
      end
   end

   // Avalon answer: one wait cycle, then ack with data
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         access_done       <= 1'b0;
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0000_0000;
      end else if (req && !access_done) begin
         access_done       <= 1'b1;
         avs_waitrequest_o <= 1'b0;
         if (avs_chipselect_hi_i) begin
            case (avs_address_i)
               `FPEG_OFS_COND_CODE: avs_readdata_o <= {24'h0, condition_code_reg};
               `FPEG_OFS_STATUS_HI: avs_readdata_o <= {24'h0, boot_s, abort_lock,
                                       busy, pwv_done, ovl_both, ovl_one, hw_stby, vpp_ok};
               default:             avs_readdata_o <= 32'h0000_0000;
            endcase
         end else begin
            case (avs_address_i)
               `FPEG_OFS_FLASH_CTRL: avs_readdata_o <= {24'h0, flash_control_reg};
               `FPEG_OFS_BLOCK_A:    avs_readdata_o <= {24'h0, erase_block_select_a};
               `FPEG_OFS_BLOCK_B:    avs_readdata_o <= {24'h0, erase_block_select_b};
               `FPEG_OFS_WAIT_STATE: avs_readdata_o <= {24'h0, wait_state_ctrl_reg};
               default:              avs_readdata_o <= 32'h0000_0000;
            endcase
         end
      end else begin
         access_done       <= 1'b0;
         avs_waitrequest_o <= 1'b1;
      end
   end

   // Unused upper lane is ignored; single byte registers
   wire unused_be = be1;
endmodule // fpeg_guard
`default_nettype wire

// ==== test/fpeg_guard_checker.sv ====
// Checker: protection, abort lock, settle time and bus answer of the guard.
// Assumes it is bound onto fpeg_guard, one clock domain, rst_i active high.
`timescale 1ns/1ns
`default_nettype none
module fpeg_guard_checker #(
   parameter NBLK_A = 8,
   parameter NBLK_B = 8
) (
   input wire logic              clk_i,
   input wire logic              rst_i,
   input wire logic              avs_read_i,
   input wire logic              avs_write_i,
   input wire logic              avs_waitrequest_o,
   input wire logic              program_voltage_pin_i,
   input wire logic              hw_standby_i,
   input wire logic              nmi_i,
   input wire logic              flash_program_o,
   input wire logic              flash_erase_o,
   input wire logic              flash_verify_write_o,
   input wire logic              flash_prewrite_verify_o,
   input wire logic              flash_read_valid_o,
   input wire logic [NBLK_A-1:0] block_enable_a_o,
   input wire logic [NBLK_B-1:0] block_enable_b_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Cycles the prewrite-verify level has stood; saturates well past the settle time
   logic [7:0] pwv_run;
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pwv_run <= 8'h00;
      end else if (!flash_prewrite_verify_o) begin
         pwv_run <= 8'h00;
      end else if (pwv_run != 8'hff) begin
         pwv_run <= pwv_run + 8'h01;
      end
   end

   // Bus answer timing; pins go through two flops, hence the four-cycle lead-ins
   chk_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |-> ##[1:2] !avs_waitrequest_o) else $error("bus answer late");
   chk_answer_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("answer stands too long");
   chk_vpp_off: assert property (!program_voltage_pin_i [*4] |->
      !flash_program_o && !flash_erase_o && !flash_verify_write_o)
      else $error("flash active without program voltage");
   chk_stby_off: assert property (hw_standby_i [*4] |->
      !flash_program_o && !flash_erase_o && !flash_verify_write_o)
      else $error("flash active in standby");
   chk_reset_clear: assert property ($fell(rst_i) |-> !flash_program_o &&
      !flash_erase_o && block_enable_a_o == 0 && block_enable_b_o == 0)
      else $error("flash state survives reset");
   chk_abort_fast: assert property (nmi_i && flash_program_o |->
      ##[0:4] !flash_program_o) else $error("interrupt did not abort");
   chk_abort_holds: assert property (nmi_i && (flash_program_o || flash_erase_o) |->
      ##5 (!flash_program_o && !flash_erase_o) [*8]) else $error("abort lock lost");
   chk_read_guard: assert property (flash_program_o && $past(flash_program_o) |->
      !flash_read_valid_o) else $error("read valid while programming");
   // Reads become valid exactly 100 cycles into an unbroken prewrite-verify stretch
   chk_pwv_settle: assert property (flash_prewrite_verify_o && pwv_run == 8'h64 |->
      flash_read_valid_o && !$past(flash_read_valid_o))
      else $error("prewrite verify settle time wrong");
   chk_block_need: assert property (flash_program_o || flash_erase_o |->
      block_enable_a_o != 0 || block_enable_b_o != 0) else $error("unselected block active");

   // Main scenarios reached
   cov_abort: cover property (nmi_i && flash_program_o);
   cov_pwv: cover property ($rose(flash_prewrite_verify_o));
   cov_erase: cover property (flash_erase_o);
endmodule // fpeg_guard_checker

bind fpeg_guard fpeg_guard_checker #(.NBLK_A(NBLK_A), .NBLK_B(NBLK_B)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_waitrequest_o(avs_waitrequest_o), .program_voltage_pin_i(program_voltage_pin_i),
   .hw_standby_i(hw_standby_i), .nmi_i(nmi_i), .flash_program_o(flash_program_o),
   .flash_erase_o(flash_erase_o), .flash_verify_write_o(flash_verify_write_o),
   .flash_prewrite_verify_o(flash_prewrite_verify_o), .flash_read_valid_o(flash_read_valid_o),
   .block_enable_a_o(block_enable_a_o), .block_enable_b_o(block_enable_b_o));
`default_nettype wire

// ==== test/fpeg_cpu_model.sv ====
// CPU side of the register bus: one read or write at a time.
// Assumes a waitrequest slave on clk_i; a wait gives up after 50 edges.
`timescale 1ns/1ns
`default_nettype none
module fpeg_cpu_model (
   input  wire logic        clk_i,
   input  wire logic        waitrequest_i,
   input  wire logic [31:0] readdata_i,
   output var  logic [3:0]  address_o,
   output var  logic        read_o,
   output var  logic        write_o,
   output var  logic [31:0] writedata_o,
   output var  logic        chipselect_hi_o
);
   int hangs = 0;

   // Idle bus at time zero
   initial begin
      address_o = 4'h0;
      read_o = 1'b0;
      write_o = 1'b0;
      writedata_o = 32'h0;
      chipselect_hi_o = 1'b0;
   end

   // Request held until waitrequest low; stale data inverted so it is never reused
   task automatic xfer(input logic rd, input logic cs, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_i);
      address_o <= a;
      chipselect_hi_o <= cs;
      writedata_o <= d;
      read_o <= rd;
      write_o <= !rd;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_i);
         if (!waitrequest_i) break;
      end
      if (n == 50) hangs++;
      q = readdata_i;
      read_o <= 1'b0;
      write_o <= 1'b0;
      writedata_o <= ~d;
   endtask
endmodule // fpeg_cpu_model
`default_nettype wire

// ==== test/test_flash_program_erase_guard.sv ====
// Self-checking bench for fpeg_guard against a small register model.
// Assumes the CPU bus model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module test_flash_program_erase_guard;
   logic        clk_i = 0;
   logic        rst_i = 1;
   logic        vpp = 1, hw_stby = 0, sw_stby = 0, boot = 0, nmi = 0, irq = 0;
   logic        rd, wr, cs, wreq, prog, ers, vw, vc, pwv, rv, vram, itk;
   logic [3:0]  addr;
   logic [7:0]  ba_o, bb_o;
   logic [15:0] maddr, cpu_addr = 16'h0;
   logic [31:0] wd, rdata;
   int          errors = 0, n_compared = 0, m_fc, m_ba, m_bb, m_ws, m_lock, i, n;

   // 25 MHz clock
   initial begin
      forever #20 clk_i = ~clk_i;
   end

   fpeg_cpu_model cpu (.clk_i(clk_i), .waitrequest_i(wreq), .readdata_i(rdata),
      .address_o(addr), .read_o(rd), .write_o(wr), .writedata_o(wd), .chipselect_hi_o(cs));

   fpeg_guard dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(addr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
      .avs_chipselect_hi_i(cs), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
      .program_voltage_pin_i(vpp), .hw_standby_i(hw_stby), .sw_standby_i(sw_stby),
      .boot_mode_i(boot), .nmi_i(nmi), .irq_i(irq), .cpu_addr_i(cpu_addr),
      .flash_program_o(prog), .flash_erase_o(ers), .flash_verify_write_o(vw),
      .flash_verify_clear_o(vc), .flash_prewrite_verify_o(pwv), .flash_read_valid_o(rv),
      .block_enable_a_o(ba_o), .block_enable_b_o(bb_o), .vector_from_ram_o(vram),
      .mapped_addr_o(maddr), .irq_taken_o(itk));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out;
      errors += cpu.hangs;
      if (errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk_i);
   endtask

   // Register write; model drops flash writes while protected by hardware
   task automatic wreg(input logic [3:0] a, input int d);
      logic [31:0] q;
      cpu.xfer(1'b0, 1'b0, a, 32'(d), q);
      if (a == 4'hc) m_ws = d & 255;
      else if (vpp && !hw_stby) begin
         case (a)
            4'h0: m_fc = d & 15;
            4'h4: m_ba = d & 255;
            default: m_bb = d & 255;
         endcase
      end
      tick(4);
   endtask

   task automatic rchk(input logic c, input logic [3:0] a, input int e, input string what);
      logic [31:0] q;
      cpu.xfer(1'b1, c, a, 32'h0, q);
      check(what, q, 32'(e));
   endtask

   // Expected flash controls, looked at mid-cycle where outputs are settled
   task automatic outs;
      int pe;
      @(negedge clk_i);
      pe = vpp && !hw_stby && !m_lock && (m_ba || m_bb) && (m_ws[7] == m_ws[6]);
      check("program", 32'(prog), 32'(pe && m_fc[0]));
      check("erase", 32'(ers), 32'(pe && m_fc[1]));
      check("verify", 32'(vw), 32'(vpp && !hw_stby && m_fc[2]));
      check("verify_clear", 32'(vc), 32'(vpp && !hw_stby && m_fc[3]));
      check("block_a", 32'(ba_o), 32'((m_ws[7] ^ m_ws[6]) ? 0 : m_ba));
      check("block_b", 32'(bb_o), 32'((m_ws[7] ^ m_ws[6]) ? 0 : m_bb));
   endtask

   task automatic model_reset;
      m_fc = 0;
      m_ba = 0;
      m_bb = 0;
      m_ws = 8;
      m_lock = 0;
   endtask

   initial begin
      tick(100000);
      errors++;
      close_out();
   end

   initial begin
      void'($urandom(95237));
      model_reset();
      tick(20);
      rst_i <= 1'b0;
      rchk(0, 4'hc, 8, "wait_state");
      rchk(1, 4'h0, 8'h80, "cond_code");
      rchk(1, 4'h8, 0, "unmapped");
      wreg(4'h0, 1);
      outs();
      // Each overlap setting against program, erase and verify
      wreg(4'h4, $urandom_range(1, 255));
      for (i = 0; i < 4; i++) begin
         wreg(4'hc, {i[1:0], 6'h08});
         for (n = 0; n < 4; n++) begin
            wreg(4'h0, 1 << n);
            outs();
         end
      end
      // Program then prewrite verify with both overlap bits set
      wreg(4'h0, 1);
      outs();
      wreg(4'h0, 0);
      check("pwv", 32'(pwv), 1);
      check("not_settled", 32'(rv), 0);
      for (n = 0; n < 300 && !rv; n++)
         tick(1);
      check("settle", 32'(n >= 96 && n <= 100), 1);
      // Program voltage removed
      tick(1);
      vpp <= 1'b0;
      tick(6);
      model_reset();
      m_ws = 8'hc8;
      rchk(0, 4'h4, 0, "block_a");
      wreg(4'h0, 1);
      outs();
      check("pwv_off", 32'(pwv), 0);
      tick(1);
      vpp <= 1'b1;
      tick(6);
      wreg(4'h8, $urandom_range(1, 255));
      wreg(4'h0, 1);
      outs();
      // Masked request leaves programming alone; NMI aborts and maps vectors
      tick(1);
      irq <= 1'b1;
      tick(6);
      outs();
      check("irq_masked", 32'(itk), 0);
      tick(1);
      irq <= 1'b0;
      nmi <= 1'b1;
      cpu_addr <= 16'($urandom_range(0, 16'h7f));
      tick(6);
      m_lock = 1;
      outs();
      check("vec_ram", 32'(vram), 1);
      check("mapped", 32'(maddr), 32'(cpu_addr | 16'hf800));
      check("irq_nmi", 32'(itk), 1);
      tick(1);
      nmi <= 1'b0;
      rchk(0, 4'h0, 1, "ctrl_kept");
      wreg(4'h0, 1);
      outs();
      wreg(4'h0, 4);
      outs();
      tick(1);
      rst_i <= 1'b1;
      tick(12);
      rst_i <= 1'b0;
      model_reset();
      rchk(0, 4'hc, 8, "ws_reset");
      wreg(4'h4, $urandom_range(1, 255));
      wreg(4'h0, 2);
      outs();
      // Boot mode overlap, then cleared by software
      tick(1);
      boot <= 1'b1;
      wreg(4'hc, 8'hc8);
      check("boot_vec", 32'(vram), 1);
      // Fetches past the window pass through; the vector slot lands in RAM
      cpu_addr <= 16'h0080;
      tick(2);
      check("vec_outside", 32'(maddr), 32'h0000_0080);
      cpu_addr <= 16'h0006;
      tick(2);
      check("vec_nmi", 32'(maddr), 32'h0000_f806);
      wreg(4'hc, 8'h08);
      check("boot_off", 32'(vram), 0);
      boot <= 1'b0;
      // Software standby keeps wait states, hardware standby clears them
      wreg(4'hc, 8'hc8);
      wreg(4'h0, 1);
      sw_stby <= 1'b1;
      tick(6);
      sw_stby <= 1'b0;
      m_fc = 0;
      m_ba = 0;
      outs();
      rchk(0, 4'hc, 8'hc8, "ws_sw_stby");
      tick(1);
      hw_stby <= 1'b1;
      tick(6);
      outs();
      tick(1);
      hw_stby <= 1'b0;
      tick(4);
      rchk(0, 4'hc, 8, "ws_hw_stby");
      close_out();
   end
endmodule // test_flash_program_erase_guard
`default_nettype wire
